// ---- dv/tb_output_phase_sync_feedback.sv ----
`timescale 1ns/1ns
module tb_output_phase_sync_feedback;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        sync_pin;
  logic        external_feedback_input;
  logic [5:0]  divided_clock_output;
  logic [5:0]  half_step_out;
  logic        first_loop_fb_clk;
  logic        second_loop_fb_clk;
  int          bad_count;
  int          checks;

  ophsf_top ophsf_top_inst (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .sync_pin                (sync_pin),
    .external_feedback_input (external_feedback_input),
    .divided_clock_output    (divided_clock_output),
    .half_step_out           (half_step_out),
    .first_loop_fb_clk       (first_loop_fb_clk),
    .second_loop_fb_clk      (second_loop_fb_clk)
  );

  // 50 MHz distribution clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobes; a gap cycle follows so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [31:0] ctrl_word(input logic q, input logic en, input logic [2:0] sel,
                                            input logic pol, input logic [4:0] mode);
    return {21'h0, mode, pol, sel, en, q};
  endfunction

  // status polling is bounded so a stuck engine ends the run instead of hanging
  task automatic wait_busy(input logic want);
    logic [31:0] s;
    for (int i = 0; i < 30; i++) begin
      rd(ophsf_pkg::ADDR_STATUS, s);
      if (s[0] === want) return;
    end
    bad_count++;
    $display("BAD busy wait expected %h seen %h", want, s[0]);
    print_verdict();
  endtask

  task automatic test_reset;
    logic [31:0] d;
    rd(ophsf_pkg::ADDR_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    rd(ophsf_pkg::ADDR_PWR, d);
    chk("pwr reset", 32'h0, d);
    for (int i = 0; i < 6; i++) begin
      rd(ophsf_pkg::ADDR_CHAN0 + 8'(4 * i), d);
      chk("chan reset", 32'h502, d);
    end
    rd(8'h40, d);
    chk("unmapped read", 32'h0, d);
  endtask

  // out1 delay 9 with half step, out2 delay 5, out0 exempt; sync by polarity toggle
  task automatic test_sync_timing;
    int t1, t2, run1, run2, r2, low0;
    logic [5:0] o, p;
    t1 = 0; t2 = 0; run1 = 0; run2 = 0; r2 = 0; low0 = 0;
    p = 6'h3f;
    wr(ophsf_pkg::ADDR_CHAN0 + 8'h04, 32'h1502);
    wr(ophsf_pkg::ADDR_CHAN0 + 8'h04, 32'h1902);
    wr(ophsf_pkg::ADDR_PWR, 32'h10000);
    chk("half step before sync", 32'h0, half_step_out[1]);
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0, 1'b1, 5'h0));
    for (int i = 1; i <= 40; i++) begin
      @(posedge core_clk);
      #1 o = divided_clock_output;
      if (o[0] === 1'b0 && p[0] === 1'b0) low0++;
      if (o[1] === 1'b0) run1++;
      else begin
        if (run1 >= 3 && t1 == 0) t1 = i;
        run1 = 0;
      end
      if (o[2] === 1'b0) run2++;
      else begin
        if (run2 >= 3 && t2 == 0) begin
          t2 = i;
          r2 = run2;
        end
        run2 = 0;
      end
      p = o;
    end
    chk("exempt output stalls", 32'h0, low0);
    chk("forced low span ok", 32'h1, r2 == 13 || r2 == 14);
    chk("rise spread", 32'h4, t1 - t2);
    chk("half step after sync", 32'h1, half_step_out[1]);
    // output one qualifies the next sync, and its divide is even
    wr(ophsf_pkg::ADDR_CHAN0 + 8'h04, 32'h0902);
  endtask

  // refused qualified syncs, then a valid one with output one qualifying itself
  task automatic test_qualify;
    logic [31:0] s;
    wr(ophsf_pkg::ADDR_PWR, 32'h4);
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b1, 3'h1, 1'b0, 5'h0));
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b1, 3'h1, 1'b1, 5'h0));
    repeat (8) @(posedge core_clk);
    rd(ophsf_pkg::ADDR_STATUS, s);
    chk("busy with group two down", 32'h0, s[0]);
    wr(ophsf_pkg::ADDR_PWR, 32'h0);
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b0, 3'h1, 1'b0, 5'h0));
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b0, 3'h1, 1'b1, 5'h0));
    repeat (8) @(posedge core_clk);
    rd(ophsf_pkg::ADDR_STATUS, s);
    chk("busy with selector off", 32'h0, s[0]);
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b1, 3'h1, 1'b0, 5'h0));
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b1, 1'b1, 3'h1, 1'b1, 5'h0));
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  // backward step of output one from half step zero; a single-cycle pin pulse must still sync
  task automatic test_sync_pin;
    wr(ophsf_pkg::ADDR_CTRL, 32'h0);
    wr(ophsf_pkg::ADDR_CHAN0 + 8'h04, 32'h1502);
    @(posedge core_clk);
    sync_pin <= 1'b1;
    @(posedge core_clk);
    sync_pin <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    // the restart comes five plus delay cycles after the engine goes idle
    repeat (12) @(posedge core_clk);
    #1 chk("half step after pin sync", 32'h1, half_step_out[1]);
  endtask

  task automatic test_feedback;
    logic [4:0]  modes [8] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0b, 5'h10};
    logic [31:0] s;
    int          hi;
    @(posedge core_clk);
    external_feedback_input <= 1'b1;
    foreach (modes[i]) begin
      wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b0, 1'b1, 3'h6, 1'b0, modes[i]));
      repeat (3) @(posedge core_clk);
      #1;
      chk("first loop fb", 32'(modes[i] == 5'h02), first_loop_fb_clk);
      chk("second loop fb", 32'(modes[i] == 5'h08), second_loop_fb_clk);
      rd(ophsf_pkg::ADDR_STATUS, s);
      chk("zero delay mode", 32'(modes[i] inside {5'h02, 5'h05, 5'h08}), s[3]);
    end
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h6, 1'b0, 5'h02));
    repeat (3) @(posedge core_clk);
    #1 chk("feedback with selector off", 32'h0, first_loop_fb_clk);
    // output one divides by two like every other output, and its pin is dark
    wr(ophsf_pkg::ADDR_PWR, 32'h200);
    wr(ophsf_pkg::ADDR_CTRL, ctrl_word(1'b0, 1'b1, 3'h1, 1'b0, 5'h02));
    hi = 0;
    repeat (6) begin
      @(posedge core_clk);
      #1 if (first_loop_fb_clk === 1'b1) hi++;
      if (divided_clock_output[1] !== 1'b0) hi = 100;
    end
    chk("powered down output feeds back", 32'h1, hi > 0 && hi < 6);
  endtask

  initial begin
    bad_count = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sync_pin = 1'b0;
    external_feedback_input = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset();
    test_sync_timing();
    test_qualify();
    test_sync_pin();
    test_feedback();
    print_verdict();
  end
endmodule

// ---- src/ophsf_pkg.sv ----
package ophsf_pkg;

  // output channels and field widths
  localparam int unsigned NUM_OUT   = 6;
  localparam int unsigned DIV_W     = 8;
  localparam int unsigned DDLY_W    = 4;
  localparam int unsigned REL_W     = 5;
  localparam int unsigned OS_W      = 4;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PWR    = 8'h04;
  localparam logic [7:0] ADDR_CHAN0  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // control register field positions
  localparam int unsigned CTRL_QUAL_BIT  = 0;
  localparam int unsigned CTRL_FBEN_BIT  = 1;
  localparam int unsigned CTRL_SEL_LSB   = 2;
  localparam int unsigned CTRL_POL_BIT   = 5;
  localparam int unsigned CTRL_MODE_LSB  = 6;
  // power / exemption register field positions
  localparam int unsigned PWR_GPD_LSB    = 0;
  localparam int unsigned PWR_OPD_LSB    = 8;
  localparam int unsigned PWR_EXEMPT_LSB = 16;
  // status register field positions
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_PEND_BIT    = 1;
  localparam int unsigned ST_QOK_BIT     = 2;
  localparam int unsigned ST_ZD_BIT      = 3;
  localparam int unsigned ST_CONF_BIT    = 4;
  localparam int unsigned ST_HOLD_LSB    = 8;
  localparam int unsigned ST_LVL_LSB     = 16;

  // feedback selector codes: 0..5 pick an output, this one the external input
  localparam logic [2:0] FB_SEL_EXT    = 3'h6;
  // output group whose power-down gates qualification
  localparam int unsigned QUAL_GROUP   = 2;

  // device mode codes
  localparam logic [4:0] MODE_ZD_DUAL_INT  = 5'h02;
  localparam logic [4:0] MODE_DUAL_EXT     = 5'h03;
  localparam logic [4:0] MODE_ZD_DUAL_EXT  = 5'h05;
  localparam logic [4:0] MODE_ZD_SINGLE    = 5'h08;
  localparam logic [4:0] MODE_SINGLE_EXT   = 5'h0b;

  // sync timing in distribution cycles
  localparam logic [OS_W-1:0]  ONESHOT_CYCLES  = 4'h8;
  localparam logic [OS_W-1:0]  FORCE_LOW_DELAY = 4'h5;
  localparam logic [REL_W-1:0] RISE_BASE       = 5'h05;

  // reset values
  localparam logic [DIV_W-1:0]  DIV_RST  = 8'h02;
  localparam logic [DDLY_W-1:0] DDLY_RST = 4'h5;

  // per-output settings: half step, digital delay, divide
  typedef struct packed {
    logic              half_step_flag;
    logic [DDLY_W-1:0] digital_delay_count;
    logic [DIV_W-1:0]  output_divide_value;
  } ophsf_chan_t;

  localparam int unsigned CHAN_W = $bits(ophsf_chan_t);

  typedef struct packed {
    logic [4:0] device_mode;
    logic       sync_polarity_invert;
    logic [2:0] feedback_select;
    logic       feedback_mux_enable;
    logic       sync_qualify_select;
  } ophsf_ctrl_t;

  typedef enum logic [2:0] {
    OPHSF_IDLE,
    OPHSF_WAIT_F1,
    OPHSF_WAIT_F2,
    OPHSF_PULSE
  } ophsf_state_t;

  function automatic logic ophsf_zero_delay(input logic [4:0] mode);
    return (mode == MODE_ZD_DUAL_INT) || (mode == MODE_ZD_DUAL_EXT) ||
           (mode == MODE_ZD_SINGLE);
  endfunction

  function automatic logic ophsf_ext_vco(input logic [4:0] mode);
    return (mode == MODE_DUAL_EXT) || (mode == MODE_ZD_DUAL_EXT) ||
           (mode == MODE_SINGLE_EXT);
  endfunction

endpackage

// ---- src/ophsf_top.sv ----
// Overview of operation
// - with qualify select set, each sync waits on edges of a chosen output
// - qualification needs the group two power-down bit at zero
// - selector powers and qualifies only while its enable bit is set
// - selector value one makes output one its own qualifying clock
// - sync-exempt outputs ignore sync and keep toggling
// - after sync the output takes the newly programmed delay and half step
// - a one-shot stretches every sync so any toggle timing works
// - one-shot starts after the second qualifying falling edge
// - synced outputs forced low five cycles after one-shot start
// - synced outputs rise five plus delay cycles after one-shot end
// - in dual-loop zero-delay modes the selected output drives the first loop divider
// - all synced outputs keep a fixed phase to the reference in zero-delay mode, offset by each one's digital delay
// - selector picks any group's output or the external feedback input
// - a powered-down output still feeds back while its group is powered
// - with an external oscillator, feedback must be internal
// - modes two, five and eight are the zero-delay configurations
`timescale 1ns/1ns
module ophsf_top (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic [ophsf_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ophsf_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ophsf_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                          sync_pin,
  input  wire logic                          external_feedback_input,
  output logic      [ophsf_pkg::NUM_OUT-1:0] divided_clock_output,
  output logic      [ophsf_pkg::NUM_OUT-1:0] half_step_out,
  output logic                               first_loop_fb_clk,
  output logic                               second_loop_fb_clk
);

  localparam int unsigned N = ophsf_pkg::NUM_OUT;

  ophsf_pkg::ophsf_ctrl_t               ctrl_q;
  ophsf_pkg::ophsf_chan_t               chan_q [N];
  logic [N-1:0]                         gpd_q;
  logic [N-1:0]                         opd_q;
  logic [N-1:0]                         exempt_q;
  logic [ophsf_pkg::DATA_W-1:0]         rdata_q;
  logic                                 sync_meta_q;
  logic                                 sync_sync_q;
  logic                                 sync_lvl_q;
  logic                                 sync_evt;
  logic                                 pend_q;
  ophsf_pkg::ophsf_state_t              state_q;
  logic [ophsf_pkg::OS_W-1:0]           os_q;
  logic                                 qual_ok;
  logic                                 qclk;
  logic                                 qprev_q;
  logic                                 qfall;
  logic                                 take;
  logic                                 force_evt;
  logic                                 pulse_end;
  logic [N-1:0]                         hold_q;
  logic [N-1:0]                         hold_d;
  logic [N-1:0]                         busy_q;
  logic [N-1:0]                         busy_d;
  logic [ophsf_pkg::REL_W-1:0]          rel_q  [N];
  logic [ophsf_pkg::REL_W-1:0]          rel_d  [N];
  logic [ophsf_pkg::DIV_W-1:0]          dcnt_q [N];
  logic [ophsf_pkg::DIV_W-1:0]          dcnt_d [N];
  logic [N-1:0]                         lvl_q;
  logic [N-1:0]                         lvl_d;
  logic [N-1:0]                         out_q;
  logic [N-1:0]                         hs_q;
  logic [N-1:0]                         hs_d;
  logic                                 fb_src;
  logic                                 fb_conflict;
  logic                                 zd_mode;
  logic                                 first_fb_q;
  logic                                 second_fb_q;

  // high for the first half of the divide period; odd divides get the longer high half
  function automatic logic div_high(input logic [7:0] cnt, input logic [7:0] div);
    logic [8:0] half;
    half = ({1'b0, div} + 9'h001) >> 1;
    return ({1'b0, cnt} < half);
  endfunction

  // register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q   <= '0;
      gpd_q    <= '0;
      opd_q    <= '0;
      exempt_q <= '0;
      for (int i = 0; i < N; i++) begin
        chan_q[i] <= '{half_step_flag: 1'b0,
                       digital_delay_count: ophsf_pkg::DDLY_RST,
                       output_divide_value: ophsf_pkg::DIV_RST};
      end
    end else if (reg_wr) begin
      if (reg_addr == ophsf_pkg::ADDR_CTRL) begin
        ctrl_q <= reg_wdata[ophsf_pkg::CTRL_MODE_LSB+4:0];
      end
      if (reg_addr == ophsf_pkg::ADDR_PWR) begin
        gpd_q    <= reg_wdata[ophsf_pkg::PWR_GPD_LSB +: N];
        opd_q    <= reg_wdata[ophsf_pkg::PWR_OPD_LSB +: N];
        exempt_q <= reg_wdata[ophsf_pkg::PWR_EXEMPT_LSB +: N];
      end
      for (int i = 0; i < N; i++) begin
        if (reg_addr == ophsf_pkg::ADDR_CHAN0 + 8'(4 * i)) begin
          chan_q[i] <= reg_wdata[ophsf_pkg::CHAN_W-1:0];
        end
      end
    end
  end

  // register reads; unmapped addresses answer zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= '0;
      if (reg_addr == ophsf_pkg::ADDR_CTRL) begin
        rdata_q <= 32'(ctrl_q);
      end
      if (reg_addr == ophsf_pkg::ADDR_PWR) begin
        rdata_q[ophsf_pkg::PWR_GPD_LSB +: N]    <= gpd_q;
        rdata_q[ophsf_pkg::PWR_OPD_LSB +: N]    <= opd_q;
        rdata_q[ophsf_pkg::PWR_EXEMPT_LSB +: N] <= exempt_q;
      end
      for (int i = 0; i < N; i++) begin
        if (reg_addr == ophsf_pkg::ADDR_CHAN0 + 8'(4 * i)) begin
          rdata_q <= 32'(chan_q[i]);
        end
      end
      if (reg_addr == ophsf_pkg::ADDR_STATUS) begin
        rdata_q[ophsf_pkg::ST_BUSY_BIT]         <= (state_q != ophsf_pkg::OPHSF_IDLE);
        rdata_q[ophsf_pkg::ST_PEND_BIT]         <= pend_q;
        rdata_q[ophsf_pkg::ST_QOK_BIT]          <= qual_ok;
        rdata_q[ophsf_pkg::ST_ZD_BIT]           <= zd_mode;
        rdata_q[ophsf_pkg::ST_CONF_BIT]         <= fb_conflict;
        rdata_q[ophsf_pkg::ST_HOLD_LSB +: N]    <= hold_q;
        rdata_q[ophsf_pkg::ST_LVL_LSB +: N]     <= lvl_q;
      end
    end
  end

  // two-flop synchroniser, then polarity applied after the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_meta_q <= 1'b0;
      sync_sync_q <= 1'b0;
      sync_lvl_q  <= 1'b0;
    end else begin
      sync_meta_q <= sync_pin;
      sync_sync_q <= sync_meta_q;
      sync_lvl_q  <= sync_sync_q ^ ctrl_q.sync_polarity_invert;
    end
  end

  // a rising effective level is one request, whether from pin or polarity bit
  assign sync_evt = (sync_sync_q ^ ctrl_q.sync_polarity_invert) & ~sync_lvl_q;

  // qualifier usable only with the selector enabled and group two powered
  assign qual_ok = ctrl_q.feedback_mux_enable && !gpd_q[ophsf_pkg::QUAL_GROUP] &&
                   (ctrl_q.feedback_select < 3'(N));
  // the selected output is its own qualifier when it is the one being moved
  assign qclk  = (ctrl_q.feedback_select < 3'(N)) ? lvl_q[ctrl_q.feedback_select] :
                 1'b0;
  assign qfall = qprev_q & ~qclk;
  assign take  = (state_q == ophsf_pkg::OPHSF_IDLE) && (sync_evt || pend_q);
  assign force_evt = (state_q == ophsf_pkg::OPHSF_PULSE) &&
                     (os_q == ophsf_pkg::FORCE_LOW_DELAY - 4'h1);
  assign pulse_end = (state_q == ophsf_pkg::OPHSF_PULSE) &&
                     (os_q == ophsf_pkg::ONESHOT_CYCLES - 4'h1);

  // a request that lands while a sync is in flight is kept, not lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (sync_evt && state_q != ophsf_pkg::OPHSF_IDLE) begin
      pend_q <= 1'b1;
    end else if (take) begin
      pend_q <= 1'b0;
    end
  end

  // sync sequencer: latch, two qualifying falls, fixed-width one-shot
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ophsf_pkg::OPHSF_IDLE;
      os_q    <= '0;
      qprev_q <= 1'b0;
    end else begin
      qprev_q <= qclk;
      case (state_q)
        ophsf_pkg::OPHSF_IDLE: begin
          os_q <= '0;
          if (take) begin
            if (!ctrl_q.sync_qualify_select) begin
              state_q <= ophsf_pkg::OPHSF_PULSE;
            end else if (qual_ok) begin
              state_q <= ophsf_pkg::OPHSF_WAIT_F1;
            end
            // qualified request with no usable qualifier is dropped
          end
        end
        ophsf_pkg::OPHSF_WAIT_F1: begin
          if (qfall) begin
            state_q <= ophsf_pkg::OPHSF_WAIT_F2;
          end
        end
        ophsf_pkg::OPHSF_WAIT_F2: begin
          if (qfall) begin
            state_q <= ophsf_pkg::OPHSF_PULSE;
          end
        end
        ophsf_pkg::OPHSF_PULSE: begin
          // width is fixed here, so the input needs no timing of its own
          if (pulse_end) begin
            state_q <= ophsf_pkg::OPHSF_IDLE;
          end else begin
            os_q <= os_q + 4'h1;
          end
        end
        default: begin
          state_q <= ophsf_pkg::OPHSF_IDLE;
        end
      endcase
    end
  end

  // per-output divider, force-low and delayed restart
  always_comb begin
    for (int i = 0; i < N; i++) begin
      hold_d[i] = hold_q[i];
      busy_d[i] = busy_q[i];
      rel_d[i]  = rel_q[i];
      dcnt_d[i] = dcnt_q[i];
      hs_d[i]   = hs_q[i];
      if (gpd_q[i]) begin
        hold_d[i] = 1'b0;
        busy_d[i] = 1'b0;
        dcnt_d[i] = '0;
      end else if (force_evt && !exempt_q[i]) begin
        hold_d[i] = 1'b1;
      end else if (pulse_end && hold_q[i]) begin
        // common base for every synced output keeps them aligned to each other
        busy_d[i] = 1'b1;
        rel_d[i]  = ophsf_pkg::RISE_BASE +
                    5'(chan_q[i].digital_delay_count);
      end else if (busy_q[i]) begin
        if (rel_q[i] == 5'h01) begin
          busy_d[i] = 1'b0;
          hold_d[i] = 1'b0;
          dcnt_d[i] = '0;
          hs_d[i]   = chan_q[i].half_step_flag;
        end else begin
          rel_d[i] = rel_q[i] - 5'h01;
        end
      end else if (!hold_q[i]) begin
        if ({1'b0, dcnt_q[i]} + 9'h001 >= {1'b0, chan_q[i].output_divide_value}) begin
          dcnt_d[i] = '0;
        end else begin
          dcnt_d[i] = dcnt_q[i] + 8'h01;
        end
      end
      lvl_d[i] = !hold_d[i] && !gpd_q[i] &&
                 div_high(dcnt_d[i], chan_q[i].output_divide_value);
    end
  end

  // pin power-down gates only the pin, so a dark output can still feed back
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_q <= '0;
      busy_q <= '0;
      lvl_q  <= '0;
      out_q  <= '0;
      hs_q   <= '0;
      for (int i = 0; i < N; i++) begin
        rel_q[i]  <= '0;
        dcnt_q[i] <= '0;
      end
    end else begin
      hold_q <= hold_d;
      busy_q <= busy_d;
      lvl_q  <= lvl_d;
      out_q  <= lvl_d & ~opd_q;
      hs_q   <= hs_d;
      for (int i = 0; i < N; i++) begin
        rel_q[i]  <= rel_d[i];
        dcnt_q[i] <= dcnt_d[i];
      end
    end
  end

  // feedback selector: an internal output level or the external input
  assign zd_mode     = ophsf_pkg::ophsf_zero_delay(ctrl_q.device_mode);
  assign fb_conflict = (ctrl_q.feedback_select == ophsf_pkg::FB_SEL_EXT) &&
                       ophsf_pkg::ophsf_ext_vco(ctrl_q.device_mode);
  always_comb begin
    fb_src = 1'b0;
    if (ctrl_q.feedback_select < 3'(N)) begin
      fb_src = lvl_q[ctrl_q.feedback_select];
    end else if (ctrl_q.feedback_select == ophsf_pkg::FB_SEL_EXT && !fb_conflict) begin
      fb_src = external_feedback_input;
    end
  end

  // dual-loop zero-delay modes feed the first loop, single-loop zero-delay mode feeds the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_fb_q  <= 1'b0;
      second_fb_q <= 1'b0;
    end else begin
      first_fb_q  <= ctrl_q.feedback_mux_enable && zd_mode &&
                     (ctrl_q.device_mode != ophsf_pkg::MODE_ZD_SINGLE) && fb_src;
      second_fb_q <= ctrl_q.feedback_mux_enable &&
                     (ctrl_q.device_mode == ophsf_pkg::MODE_ZD_SINGLE) && fb_src;
    end
  end

  assign reg_rdata            = rdata_q;
  assign divided_clock_output = out_q;
  assign half_step_out        = hs_q;
  assign first_loop_fb_clk    = first_fb_q;
  assign second_loop_fb_clk   = second_fb_q;

  // checks on the sync sequence and the feedback path
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  qual_gate_a: assert property (take && ctrl_q.sync_qualify_select && qual_ok
    |=> state_q == ophsf_pkg::OPHSF_WAIT_F1) else $error("qualified sync did not wait");
  group_two_pd_a: assert property (take && ctrl_q.sync_qualify_select &&
    gpd_q[ophsf_pkg::QUAL_GROUP] |=> state_q == ophsf_pkg::OPHSF_IDLE)
    else $error("sync qualified with group two down");
  mux_off_a: assert property (!ctrl_q.feedback_mux_enable
    |=> !first_fb_q && !second_fb_q) else $error("feedback with selector off");
  exempt_run_a: assert property (exempt_q[0] && !gpd_q[0] && !hold_q[0]
    |=> !hold_q[0]) else $error("exempt output was held");
  two_falls_a: assert property (state_q == ophsf_pkg::OPHSF_WAIT_F2 && qfall
    |=> state_q == ophsf_pkg::OPHSF_PULSE && os_q == 4'h0) else $error("pulse not after fall");
  force_low_a: assert property (state_q == ophsf_pkg::OPHSF_PULSE &&
    os_q == 4'h0 && !exempt_q[0] && !gpd_q[0] && !hold_q[0] ##0 (!gpd_q[0])[*5]
    |-> !hold_q[0] ##1 hold_q[0] && !lvl_q[0]) else $error("output not forced low on time");
  rise_load_a: assert property (pulse_end && hold_q[0] && !gpd_q[0]
    |=> busy_q[0] && rel_q[0] == 5'h05 + 5'($past(chan_q[0].digital_delay_count)))
    else $error("restart delay wrong");
  new_phase_a: assert property (busy_q[0] && rel_q[0] == 5'h01 && !gpd_q[0]
    |=> lvl_q[0] && !hold_q[0] && hs_q[0] == $past(chan_q[0].half_step_flag))
    else $error("output not restarted at new phase");
  zd_route_a: assert property (ctrl_q.feedback_mux_enable &&
    ctrl_q.device_mode == ophsf_pkg::MODE_ZD_DUAL_INT && ctrl_q.feedback_select == 3'h1
    |=> first_fb_q == $past(lvl_q[1])) else $error("first loop feedback wrong");
  ext_vco_a: assert property (fb_conflict |=> !first_fb_q && !second_fb_q)
    else $error("external feedback used with external oscillator");
  sync_pipe_a: assert property ($rose(sync_sync_q) |-> $past(sync_meta_q))
    else $error("synchroniser stage skipped");

  pulse_c: cover property (state_q == ophsf_pkg::OPHSF_WAIT_F2 ##1
    state_q == ophsf_pkg::OPHSF_PULSE);
  restart_c: cover property (busy_q[1] ##1 !busy_q[1] && lvl_q[1]);
  pending_c: cover property (sync_evt && state_q != ophsf_pkg::OPHSF_IDLE);

endmodule
